/* File: verilog/gti_top.sv */
// Functional notes
// - Only interrupt status drives request; CMD summary
// - Bit 7 summary set on any enabled condition
// - Request output gated by mask bit 7
// - Address status never interrupts by itself
// - Entering talker active sets byte-out flag if no byte is pending
// - Listener capture sets byte-in flag
// - Talker active only after ATN released
// - Data-out write clears flag, drives byte
// - DAV only after RFD true
// - Talker drives DAV; listeners drive DAC, RFD
// - Byte accepted in talker active sets byte-out
// - ATN leaves talker active, clears byte-out
// - Untalk gives talker idle, flag stays clear
// - Re-talked device sets byte-out on ATN release if no byte is pending
// - Command hold-off holds every command handshake
// - ATN bit stays until held command is released
// - Write 0x10 clears hold-off, releases command
// - Data-in read releases DAC, clears flags
module gti_top (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// Host register port
	input  wire logic         cs,
	input  wire logic [2:0]   rs,
	input  wire logic         we,
	input  wire logic         re,
	input  wire gti_pkg::gti_byte_t wdata,
	output gti_pkg::gti_byte_t     rdata,
	output logic              irq_n,
	// Address and command status from surrounding logic
	input  wire logic         my_talk_addr,
	input  wire logic         untalk,
	input  wire logic         listen_active,
	input  wire gti_pkg::gti_byte_t cmd_status,
	// Bus management lines, true is 1
	input  wire logic         atn_in,
	input  wire logic         eoi_in,
	output logic              eoi_out,
	// Bus data lines
	input  wire gti_pkg::gti_byte_t dio_in,
	output gti_pkg::gti_byte_t     dio_out,
	output logic              dio_oe_n,
	// Bus handshake lines
	input  wire logic         dav_in,
	input  wire logic         rfd_in,
	input  wire logic         dac_in,
	output logic              dav_out,
	output logic              talk_oe_n,
	output logic              rfd_out,
	output logic              dac_out,
	output logic              acc_oe_n
);
	import gti_pkg::*;

	gti_src_if hs ();

	gti_source u_source (
		.clock (clock),
		.rst   (rst),
		.hs    (hs)
	);

	// Host side state
	gti_byte_t mask_r,    mask_nxt;
	gti_byte_t status_r,  status_nxt;
	gti_byte_t din_r,     din_nxt;
	gti_byte_t dout_r,    dout_nxt;
	gti_byte_t rdata_r,   rdata_nxt;
	logic      swrst_r,   swrst_nxt;
	logic      feoi_r,    feoi_nxt;
	logic      dacd_r,    dacd_nxt;
	logic      dacr_r,    dacr_nxt;
	logic      tads_r,    tads_nxt;
	logic      tacs_r,    tacs_nxt;
	logic      nba_r,     nba_nxt;
	logic      irq_n_r,   irq_n_nxt;
	logic      eoi_r,     eoi_nxt;
	logic      dio_oe_n_r, dio_oe_n_nxt;
	logic      talk_oe_n_r, talk_oe_n_nxt;

	// Acceptor state
	gti_acc_e  acc_r,     acc_nxt;
	logic      rfd_r,     rfd_nxt;
	logic      dac_r,     dac_nxt;
	logic      acc_oe_n_r, acc_oe_n_nxt;

	logic      wr_any;
	logic      rd_any;
	logic      wr_mask;
	logic      wr_aux;
	logic      wr_dout;
	logic      rd_din;
	logic      capture;
	logic      cmd_release;
	logic      acc_on;
	logic      atn_bit;
	gti_byte_t addr_status;

	assign wr_any  = cs & we;
	assign rd_any  = cs & re;
	assign wr_mask = wr_any & (rs == REG_INT_MASK) & !swrst_r;
	assign wr_aux  = wr_any & (rs == REG_AUX_CMD);
	assign wr_dout = wr_any & (rs == REG_DATA) & !swrst_r;
	assign rd_din  = rd_any & (rs == REG_DATA);
	assign acc_on  = !swrst_r & (atn_in | listen_active);

	// Acceptor: data bytes wait for a host read, commands may be held
	always_comb begin
		acc_nxt     = acc_r;
		capture     = 1'b0;
		cmd_release = 1'b0;
		case (acc_r)
			ACC_READY: begin
				if (acc_on && dav_in) begin
					if (atn_in) begin
						acc_nxt = dacd_r ? ACC_CHOLD : ACC_DONE;
					end else begin
						acc_nxt = ACC_DHOLD;
						capture = 1'b1;
					end
				end
			end
			ACC_DHOLD: begin
				if (rd_din || swrst_r)
					acc_nxt = ACC_DONE;
			end
			ACC_CHOLD: begin
				if (dacr_r || swrst_r) begin
					acc_nxt     = ACC_DONE;
					cmd_release = 1'b1;
				end
			end
			ACC_DONE: begin
				if (!dav_in)
					acc_nxt = ACC_READY;
			end
			default: acc_nxt = ACC_READY;
		endcase
		// Listeners drive RFD and DAC only
		rfd_nxt      = (acc_nxt == ACC_READY);
		dac_nxt      = (acc_nxt == ACC_DONE);
		acc_oe_n_nxt = !(acc_on || acc_nxt != ACC_READY);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acc_r      <= ACC_READY;
			rfd_r      <= 1'b0;
			dac_r      <= 1'b0;
			acc_oe_n_r <= 1'b1;
		end else begin
			acc_r      <= acc_nxt;
			rfd_r      <= rfd_nxt;
			dac_r      <= dac_nxt;
			acc_oe_n_r <= acc_oe_n_nxt;
		end
	end

	// ATN shows until a held command is released
	assign atn_bit = atn_in | (acc_r == ACC_CHOLD);

	always_comb begin
		addr_status          = 8'h00;
		addr_status[AS_LACS] = listen_active;
		addr_status[AS_TACS] = tacs_r;
		addr_status[AS_ATN]  = atn_bit;
	end

	// Talker, flags and host registers
	always_comb begin
		mask_nxt   = mask_r;
		status_nxt = status_r;
		din_nxt    = din_r;
		dout_nxt   = dout_r;
		swrst_nxt  = swrst_r;
		feoi_nxt   = feoi_r;
		dacd_nxt   = dacd_r;
		dacr_nxt   = 1'b0;
		tads_nxt   = tads_r;
		nba_nxt    = nba_r;
		rdata_nxt  = rdata_r;

		// While in software reset only the reset bit can be written
		if (wr_aux) begin
			swrst_nxt = wdata[AUX_RESET];
			if (!swrst_r) begin
				feoi_nxt = wdata[AUX_FEOI];
				dacd_nxt = wdata[AUX_DACD];
				dacr_nxt = wdata[AUX_DACR];
			end
		end
		if (wr_mask)
			mask_nxt = wdata;

		// Addressing from the address logic
		if (swrst_r || untalk)
			tads_nxt = 1'b0;
		else if (my_talk_addr)
			tads_nxt = 1'b1;
		tacs_nxt = tads_nxt & !atn_in & !swrst_nxt;

		// Data out goes on the lines at once; handshake armed by nba
		if (wr_dout) begin
			dout_nxt = wdata;
			nba_nxt  = 1'b1;
		end else if (hs.done) begin
			nba_nxt  = 1'b0;
			// Force-EOI covers only the byte it was set for
			feoi_nxt = 1'b0;
		end

		// Byte-out: set wins over a concurrent data-out write
		if (!tacs_nxt)
			status_nxt[ST_BO] = 1'b0;
		else if ((tacs_nxt && !tacs_r && !nba_nxt) || (hs.done && tacs_r))
			status_nxt[ST_BO] = 1'b1;
		else if (wr_dout)
			status_nxt[ST_BO] = 1'b0;

		// Byte-in and end: capture wins over the read that clears them
		if (capture) begin
			din_nxt            = dio_in;
			status_nxt[ST_BI]  = 1'b1;
			status_nxt[ST_END] = eoi_in;
		end else if (rd_din || swrst_r) begin
			status_nxt[ST_BI]  = 1'b0;
			status_nxt[ST_END] = 1'b0;
		end

		// Command status reaches interrupts only through its summary
		status_nxt[ST_CMD] = |cmd_status;
		status_nxt[6:4]    = 3'h0;
		// Summary ignores address status and the request enable
		status_nxt[ST_INT] = |(status_nxt[6:0] & mask_nxt[6:0]);

		if (swrst_nxt) begin
			status_nxt[ST_BO] = 1'b0;
			nba_nxt           = 1'b0;
		end

		if (rd_any) begin
			case (rs)
				REG_INT_STATUS:  rdata_nxt = status_r;
				REG_CMD_STATUS:  rdata_nxt = cmd_status;
				REG_ADDR_STATUS: rdata_nxt = addr_status;
				REG_DATA:        rdata_nxt = din_r;
				default:         rdata_nxt = UNMAPPED_RD;
			endcase
		end

		irq_n_nxt     = !(status_nxt[ST_INT] & mask_nxt[MASK_IRQ_EN]);
		eoi_nxt       = feoi_nxt & tacs_nxt;
		dio_oe_n_nxt  = !tacs_nxt;
		talk_oe_n_nxt = !tacs_nxt;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mask_r      <= MASK_RST;
			status_r    <= STATUS_RST;
			din_r       <= DATA_RST;
			dout_r      <= DATA_RST;
			rdata_r     <= DATA_RST;
			swrst_r     <= 1'b1;
			feoi_r      <= 1'b0;
			dacd_r      <= 1'b0;
			dacr_r      <= 1'b0;
			tads_r      <= 1'b0;
			tacs_r      <= 1'b0;
			nba_r       <= 1'b0;
			irq_n_r     <= 1'b1;
			eoi_r       <= 1'b0;
			dio_oe_n_r  <= 1'b1;
			talk_oe_n_r <= 1'b1;
		end else begin
			mask_r      <= mask_nxt;
			status_r    <= status_nxt;
			din_r       <= din_nxt;
			dout_r      <= dout_nxt;
			rdata_r     <= rdata_nxt;
			swrst_r     <= swrst_nxt;
			feoi_r      <= feoi_nxt;
			dacd_r      <= dacd_nxt;
			dacr_r      <= dacr_nxt;
			tads_r      <= tads_nxt;
			tacs_r      <= tacs_nxt;
			nba_r       <= nba_nxt;
			irq_n_r     <= irq_n_nxt;
			eoi_r       <= eoi_nxt;
			dio_oe_n_r  <= dio_oe_n_nxt;
			talk_oe_n_r <= talk_oe_n_nxt;
		end
	end

	// Source handshake hookup; a byte written before ATN survives it
	assign hs.nba    = nba_r;
	// Next-state view lets DAV fall on the very edge that sees ATN
	assign hs.active = tacs_nxt;
	assign hs.rfd    = rfd_in;
	assign hs.dac    = dac_in;

	assign rdata     = rdata_r;
	assign irq_n     = irq_n_r;
	assign eoi_out   = eoi_r;
	assign dio_out   = dout_r;
	assign dio_oe_n  = dio_oe_n_r;
	assign dav_out   = hs.dav;
	assign talk_oe_n = talk_oe_n_r;
	assign rfd_out   = rfd_r;
	assign dac_out   = dac_r;
	assign acc_oe_n  = acc_oe_n_r;
endmodule

/* File: inc/gti_pkg.sv */
package gti_pkg;
	typedef logic [7:0] gti_byte_t;

	// Register selects on the host port
	localparam logic [2:0] REG_INT_STATUS  = 3'h0;
	localparam logic [2:0] REG_INT_MASK    = 3'h0;
	localparam logic [2:0] REG_CMD_STATUS  = 3'h1;
	localparam logic [2:0] REG_ADDR_STATUS = 3'h2;
	localparam logic [2:0] REG_AUX_CMD     = 3'h3;
	localparam logic [2:0] REG_DATA        = 3'h7;

	// Interrupt status and mask bit positions
	localparam int ST_BI  = 0;
	localparam int ST_BO  = 1;
	localparam int ST_CMD = 2;
	localparam int ST_END = 3;
	localparam int ST_INT = 7;
	localparam int MASK_IRQ_EN = 7;

	// Address status bit positions
	localparam int AS_LACS = 0;
	localparam int AS_TACS = 1;
	localparam int AS_ATN  = 2;

	// Auxiliary command bit positions
	localparam int AUX_FEOI  = 1;
	localparam int AUX_DACD  = 3;
	localparam int AUX_DACR  = 4;
	localparam int AUX_RESET = 7;

	// Reset values
	localparam gti_byte_t MASK_RST   = 8'h00;
	localparam gti_byte_t STATUS_RST = 8'h00;
	localparam gti_byte_t DATA_RST   = 8'h00;
	localparam gti_byte_t UNMAPPED_RD = 8'h00;

	typedef enum logic [1:0] {
		SRC_IDLE,
		SRC_GEN,
		SRC_DLY,
		SRC_TRS
	} gti_src_e;

	typedef enum logic [1:0] {
		ACC_READY,
		ACC_DHOLD,
		ACC_CHOLD,
		ACC_DONE
	} gti_acc_e;
endpackage

/* File: inc/gti_src_if.sv */
interface gti_src_if;
	logic nba;
	logic active;
	logic rfd;
	logic dac;
	logic dav;
	logic done;

	modport src (
		input  nba,
		input  active,
		input  rfd,
		input  dac,
		output dav,
		output done
	);

	modport ctl (
		output nba,
		output active,
		output rfd,
		output dac,
		input  dav,
		input  done
	);
endinterface

/* File: verilog/gti_source.sv */
module gti_source (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Handshake to the talker control
	gti_src_if.src   hs
);
	import gti_pkg::*;

	gti_src_e state_r;
	gti_src_e state_nxt;
	logic     dav_r;
	logic     dav_nxt;
	logic     done_r;
	logic     done_nxt;

	always_comb begin
		state_nxt = state_r;
		dav_nxt   = 1'b0;
		done_nxt  = 1'b0;
		if (!hs.active) begin
			// Leaving the active state drops DAV at once
			state_nxt = SRC_IDLE;
		end else begin
			case (state_r)
				SRC_IDLE: state_nxt = SRC_GEN;
				SRC_GEN: begin
					// The nba flag clears one edge after done; skip that edge
					if (hs.nba && !done_r)
						state_nxt = SRC_DLY;
				end
				SRC_DLY: begin
					if (hs.rfd) begin
						state_nxt = SRC_TRS;
						dav_nxt   = 1'b1;
					end
				end
				SRC_TRS: begin
					dav_nxt = 1'b1;
					if (hs.dac) begin
						// One-cycle done keeps the byte from being sent twice
						state_nxt = SRC_GEN;
						dav_nxt   = 1'b0;
						done_nxt  = 1'b1;
					end
				end
				default: state_nxt = SRC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r <= SRC_IDLE;
			dav_r   <= 1'b0;
			done_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			dav_r   <= dav_nxt;
			done_r  <= done_nxt;
		end
	end

	assign hs.dav  = dav_r;
	assign hs.done = done_r;
endmodule

/* File: verification/gti_listener.sv */
module gti_listener (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Handshake
	input wire logic dav,
	input wire logic slow,
	output logic     rfd,
	output logic     dac
);
	timeunit 1ns;
	timeprecision 1ns;
	int hold;
	// Slow mode stretches the waits after RFD and DAC drop, as a sluggish listener would
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			rfd <= 1'b0;
			dac <= 1'b0;
			hold <= 0;
		end else if (hold != 0) begin
			hold <= hold - 1;
		end else if (dav && rfd) begin
			rfd <= 1'b0;
			hold <= slow ? 5 : 0;
		end else if (dav) begin
			dac <= 1'b1;
		end else if (dac) begin
			dac <= 1'b0;
			hold <= slow ? 5 : 1;
		end else begin
			rfd <= 1'b1;
		end
	end
endmodule

/* File: verification/gti_top_assertions.sv */
module gti_chk (
	// Clock and reset
	input wire logic               clock,
	input wire logic               rst,
	// Host side
	input wire logic               cs,
	input wire logic [2:0]         rs,
	input wire logic               we,
	input wire gti_pkg::gti_byte_t wdata,
	input wire gti_pkg::gti_byte_t cmd_status,
	input wire logic               irq_n,
	// Bus side
	input wire logic               atn_in,
	input wire logic               rfd_in,
	input wire logic               dac_in,
	input wire logic               dav_out,
	input wire gti_pkg::gti_byte_t dio_out,
	input wire logic               dio_oe_n
);
	import gti_pkg::*;
	logic      swrst_r;
	gti_byte_t mask_r;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Mask mirror lets irq be tied to its cause without seeing internals
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			swrst_r <= 1'b1;
			mask_r <= 8'h00;
		end else if (cs && we && rs == 3'h3) begin
			swrst_r <= wdata[7];
		end else if (cs && we && rs == 3'h0 && !swrst_r) begin
			mask_r <= wdata;
		end
	end
	chk_dav_ready: assert property ($rose(dav_out) |-> $past(rfd_in))
		else $error("dav rose without rfd");
	chk_dav_hold: assert property (dav_out && !dac_in && !atn_in |=> dav_out)
		else $error("dav dropped early");
	chk_dav_drop: assert property (dav_out && dac_in |=> !dav_out)
		else $error("dav held after accept");
	chk_atn_leave: assert property (atn_in |=> !dav_out && dio_oe_n)
		else $error("talker active under atn");
	chk_data_out: assert property (cs && we && rs == 3'h7 && !swrst_r && !dav_out
		|=> dio_out == $past(wdata)) else $error("data byte not driven");
	chk_irq_off: assert property (!mask_r[7] |-> irq_n)
		else $error("irq without enable");
	chk_cmd_irq: assert property ((cmd_status != 8'h00) ##1 (mask_r[7] && mask_r[2])
		|-> !irq_n) else $error("cmd summary gave no irq");
	chk_no_cause: assert property ((mask_r[6:0] == 7'h00) [*3] |-> irq_n)
		else $error("irq with nothing enabled");
endmodule
bind gti_top gti_chk u_chk (.clock, .rst, .cs, .rs, .we, .wdata, .cmd_status, .irq_n,
	.atn_in, .rfd_in, .dac_in, .dav_out, .dio_out, .dio_oe_n);

/* File: verification/test_gti_talker_status_interrupt.sv */
`define CHK(nm, e, g) begin \
	checked++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("mismatch %s expected %h seen %h", nm, e, g); \
	end \
end
module test_gpib_talker_status_interrupt;
	timeunit 1ns;
	timeprecision 1ns;
	import gti_pkg::*;
	logic       clock, rst, cs, we, re, my_talk_addr, untalk, listen_active, took;
	logic       atn_in, eoi_in, dav_in, rfd_in, dac_in, slow, irq_n, eoi_out, dio_oe_n;
	logic       dav_out, talk_oe_n, rfd_out, dac_out, acc_oe_n;
	logic [2:0] rs;
	gti_byte_t  wdata, rdata, cmd_status, dio_in, dio_out, d, exp_v;
	gti_byte_t  exp_q[$];
	int         miscompares, checked, cycles;
	gti_top u_dut (.clock, .rst, .cs, .rs, .we, .re, .wdata, .rdata, .irq_n, .my_talk_addr,
		.untalk, .listen_active, .cmd_status, .atn_in, .eoi_in, .eoi_out, .dio_in, .dio_out,
		.dio_oe_n, .dav_in, .rfd_in, .dac_in, .dav_out, .talk_oe_n, .rfd_out, .dac_out,
		.acc_oe_n);
	gti_listener u_lis (.clock, .rst, .dav(dav_out), .slow, .rfd(rfd_in), .dac(dac_in));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		took <= cs & re;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end
	// Read results land on the taking edge and are checked at the next falling edge
	always @(negedge clock) begin
		if (took === 1'b1 && exp_q.size() > 0) begin
			exp_v = exp_q.pop_front();
			`CHK("rdata", exp_v, rdata)
		end
	end
	task automatic idle(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic acc(input logic [2:0] a, input gti_byte_t v, input logic w);
		@(negedge clock);
		cs = 1'b1;
		rs = a;
		we = w;
		re = !w;
		wdata = v;
		if (!w) exp_q.push_back(v);
		@(negedge clock);
		cs = 1'b0;
		we = 1'b0;
		re = 1'b0;
	endtask
	task automatic addr(input logic u);
		atn_in = 1'b1;
		my_talk_addr = !u;
		untalk = u;
		idle(1);
		my_talk_addr = 1'b0;
		untalk = 1'b0;
		idle(2);
		`CHK("oe", 1'b1, dio_oe_n)
		`CHK("toe", 1'b1, talk_oe_n)
		atn_in = 1'b0;
		idle(3);
	endtask
	task automatic dav_wait(input logic v);
		for (int n = 0; n < 60 && dav_out !== v; n++) idle(1);
		`CHK("dav", v, dav_out)
	endtask
	initial begin
		{cs, we, re, my_talk_addr, untalk, listen_active, atn_in, eoi_in, dav_in, slow} = '0;
		{rs, wdata, cmd_status, dio_in} = '0;
		rst = 1'b1;
		d = $urandom(23370);
		repeat (16) @(negedge clock);
		rst = 1'b0;
		acc(3'h3, 8'h00, 1'b1);
		acc(3'h5, 8'h00, 1'b0);
		listen_active = 1'b1;
		acc(3'h0, 8'h84, 1'b1);
		idle(3);
		`CHK("irq", 1'b1, irq_n)
		cmd_status = $urandom_range(255, 1);
		idle(3);
		`CHK("irq", 1'b0, irq_n)
		acc(3'h0, 8'h04, 1'b1);
		idle(3);
		`CHK("irq", 1'b1, irq_n)
		acc(3'h0, 8'h84, 1'b0);
		acc(3'h0, 8'h00, 1'b1);
		acc(3'h0, 8'h04, 1'b0);
		{cmd_status, listen_active} = '0;
		$display("irq test done");
		addr(1'b0);
		acc(3'h0, 8'h02, 1'b0);
		for (int i = 0; i < 4; i++) begin
			slow = i[0];
			d = $urandom();
			if (i == 3) acc(3'h3, 8'h02, 1'b1);
			acc(3'h7, d, 1'b1);
			`CHK("dout", d, dio_out)
			acc(3'h0, 8'h00, 1'b0);
			dav_wait(1'b1);
			if (i == 3) `CHK("eoi", 1'b1, eoi_out)
			dav_wait(1'b0);
			idle(2);
			acc(3'h0, 8'h02, 1'b0);
		end
		$display("talker test done");
		atn_in = 1'b1;
		idle(2);
		acc(3'h0, 8'h00, 1'b0);
		addr(1'b1);
		acc(3'h0, 8'h00, 1'b0);
		addr(1'b0);
		acc(3'h0, 8'h02, 1'b0);
		$display("atn test done");
		acc(3'h3, 8'h0a, 1'b1);
		d = $urandom();
		acc(3'h7, d, 1'b1);
		dav_wait(1'b1);
		`CHK("eoi", 1'b1, eoi_out)
		dav_wait(1'b0);
		idle(2);
		{atn_in, untalk, dav_in} = 3'b111;
		idle(1);
		untalk = 1'b0;
		idle(3);
		`CHK("dac", 1'b0, dac_out)
		atn_in = 1'b0;
		acc(3'h2, 8'h04, 1'b0);
		acc(3'h3, 8'h10, 1'b1);
		idle(1);
		`CHK("dac", 1'b1, dac_out)
		acc(3'h0, 8'h02, 1'b1);
		dav_in = 1'b0;
		idle(3);
		$display("holdoff test done");
		d = $urandom();
		dio_in = d;
		{listen_active, eoi_in, dav_in} = 3'b111;
		idle(3);
		`CHK("rfd", 1'b0, rfd_out)
		`CHK("accoe", 1'b0, acc_oe_n)
		acc(3'h0, 8'h09, 1'b0);
		acc(3'h7, d, 1'b0);
		idle(1);
		`CHK("dac", 1'b1, dac_out)
		acc(3'h0, 8'h00, 1'b0);
		dav_in = 1'b0;
		idle(3);
		`CHK("rfd", 1'b1, rfd_out)
		$display("listener test done");
		final_report();
	end
endmodule
